// File: adc_conversion_sequencer.sv
// Sequencer of a ten-bit successive-approximation converter with an AXI4-Lite register slave.
// Assumes the analog core reports its result and over-range level when the conversion ends.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.

`timescale 1ns/1ns
`default_nettype none

module adc_conversion_sequencer #(
  parameter int         ADDR_W       = 8,
  parameter logic [4:0] TEMP_CHANNEL = 5'h1e
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 eventIn,
  input  wire logic [9:0]           anaResult,
  input  wire logic                 anaOverRange,
  output adc_seq_pkg::ana_ctl_t     anaCtl,
  output logic                      resultReady,
  output logic                      resultEvent
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < adc_seq_pkg::IDX_W) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end
  if (adc_seq_pkg::CLK_KHZ <= adc_seq_pkg::PERIPH_MIN_KHZ) begin : g_bad_clk
    $error("Peripheral clock below the prescaler minimum");
  end

  adc_seq_pkg::seq_t s_q;
  adc_seq_pkg::seq_t s_d;
  logic              tick;
  logic              prescRun;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [8:0] initTicks(input logic [2:0] sel);
    if (sel == 3'h0) begin
      initTicks = 9'h000;
    end else if (sel > adc_seq_pkg::INIT_SEL_MAX) begin
      initTicks = adc_seq_pkg::INIT_UNIT << adc_seq_pkg::INIT_SEL_MAX;
    end else begin
      initTicks = adc_seq_pkg::INIT_UNIT << sel;
    end
  endfunction : initTicks

  function automatic logic [8:0] sampleTicks(input logic [3:0] dly, input logic [4:0] len);
    sampleTicks = adc_seq_pkg::HOLD_CYCLES + {5'h00, dly} + {4'h0, len};
  endfunction : sampleTicks

  // Prescaler runs only while enabled and a conversion is pending or running.
  assign prescRun = s_q.enable && (s_q.startBit || s_q.st != adc_seq_pkg::ST_IDLE);

  adc_prescaler u_clock_divider_select (
    .clk    (clk),
    .arst_n (arst_n),
    .run    (prescRun),
    .divSel (s_q.divSel),
    .tick   (tick)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [8:0]  sampT;
    logic [8:0]  lastT;
    logic        doWrite;
    logic        doRead;
    logic        done;
    logic        lastCyc;
    logic        evtEdge;
    logic        setFlag;
    logic        clrFlag;
    logic [4:0]  ridx;
    sampT   = sampleTicks(s_q.sample_delay, s_q.sample_length);
    lastT   = sampT + adc_seq_pkg::CONV_CYCLES - adc_seq_pkg::HOLD_CYCLES - 9'h001;
    s_d     = s_q;
    setFlag = 1'b0;
    clrFlag = 1'b0;
    s_d.resEvt = 1'b0;
    s_d.ana.hold = 1'b0;

    // AXI write channel capture, either order.
    if (s_axi_awvalid && !s_q.awHave) begin
      s_d.awHave = 1'b1;
      s_d.awIdx  = s_axi_awaddr[adc_seq_pkg::IDX_W-1:0];
    end
    if (s_axi_wvalid && !s_q.wHave) begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    doWrite = s_q.awHave && s_q.wHave && !s_q.bValid;
    ridx    = s_axi_araddr[adc_seq_pkg::IDX_W-1:0];
    doRead  = s_axi_arvalid && !s_q.rValid;
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end

    // Event trigger on its rising edge.
    s_d.evtPrev = eventIn;
    evtEdge     = eventIn && !s_q.evtPrev && s_q.evtEn && s_q.enable;
    if (evtEdge) begin
      s_d.startBit = 1'b1;
    end

    if (doWrite) begin
      s_d.awHave = 1'b0;
      s_d.wHave  = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp  = adc_seq_pkg::RESP_OKAY;
      if (s_q.awIdx == adc_seq_pkg::OFF_CTRL) begin
        if (s_q.wStrb[0]) begin
          s_d.enable  = s_q.wData[adc_seq_pkg::CTRL_ENABLE];
          s_d.freeRun = s_q.wData[adc_seq_pkg::CTRL_FREERUN];
          s_d.evtEn   = s_q.wData[adc_seq_pkg::CTRL_EVTEN];
        end
      end else if (s_q.awIdx == adc_seq_pkg::OFF_CONF) begin
        if (s_q.wStrb[0]) begin
          s_d.divSel = s_q.wData[adc_seq_pkg::CONF_DIV_LO +: 3];
          s_d.refTmp = s_q.wData[adc_seq_pkg::CONF_REF_LO +: 2];
          s_d.capSel = s_q.wData[adc_seq_pkg::CONF_CAP];
        end
        if (s_q.wStrb[1]) begin
          s_d.sample_delay = s_q.wData[adc_seq_pkg::CONF_DLY_LO +: 4];
          s_d.initial_delay = s_q.wData[adc_seq_pkg::CONF_INIT_LO +: 3];
        end
      end else if (s_q.awIdx == adc_seq_pkg::OFF_SAMPCTRL) begin
        if (s_q.wStrb[0]) begin
          s_d.sample_length = s_q.wData[4:0];
        end
      end else if (s_q.awIdx == adc_seq_pkg::OFF_CHANNEL) begin
        if (s_q.wStrb[0]) begin
          s_d.chanTmp = s_q.wData[4:0];
        end
      end else if (s_q.awIdx == adc_seq_pkg::OFF_COMMAND) begin
        if (s_q.wStrb[0] && s_q.enable) begin
          // A one starts; a zero stops free-running after the current conversion.
          s_d.startBit = s_q.wData[0] || evtEdge || (s_q.startBit && !s_q.freeRun);
        end
      end else if (s_q.awIdx == adc_seq_pkg::OFF_FLAGS) begin
        clrFlag = s_q.wStrb[0] && s_q.wData[0];
      end else if (s_q.awIdx == adc_seq_pkg::OFF_RESULT ||
                   s_q.awIdx == adc_seq_pkg::OFF_STATUS) begin
        s_d.bResp = adc_seq_pkg::RESP_OKAY;
      end else begin
        s_d.bResp = adc_seq_pkg::RESP_SLVERR;
      end
    end

    if (doRead) begin
      s_d.rValid = 1'b1;
      s_d.rResp  = adc_seq_pkg::RESP_OKAY;
      s_d.rData  = 32'h0000_0000;
      if (ridx == adc_seq_pkg::OFF_CTRL) begin
        s_d.rData[adc_seq_pkg::CTRL_ENABLE]  = s_q.enable;
        s_d.rData[adc_seq_pkg::CTRL_FREERUN] = s_q.freeRun;
        s_d.rData[adc_seq_pkg::CTRL_EVTEN]   = s_q.evtEn;
      end else if (ridx == adc_seq_pkg::OFF_CONF) begin
        s_d.rData[adc_seq_pkg::CONF_DIV_LO +: 3]  = s_q.divSel;
        s_d.rData[adc_seq_pkg::CONF_REF_LO +: 2]  = s_q.refTmp;
        s_d.rData[adc_seq_pkg::CONF_CAP]          = s_q.capSel;
        s_d.rData[adc_seq_pkg::CONF_DLY_LO +: 4]  = s_q.sample_delay;
        s_d.rData[adc_seq_pkg::CONF_INIT_LO +: 3] = s_q.initial_delay;
      end else if (ridx == adc_seq_pkg::OFF_SAMPCTRL) begin
        s_d.rData[4:0] = s_q.sample_length;
      end else if (ridx == adc_seq_pkg::OFF_CHANNEL) begin
        s_d.rData[4:0] = s_q.chanTmp;
      end else if (ridx == adc_seq_pkg::OFF_COMMAND) begin
        s_d.rData[0] = s_q.startBit;
      end else if (ridx == adc_seq_pkg::OFF_FLAGS) begin
        s_d.rData[0] = s_q.flag;
      end else if (ridx == adc_seq_pkg::OFF_RESULT) begin
        s_d.rData[9:0] = s_q.result;
        clrFlag        = 1'b1;
      end else if (ridx == adc_seq_pkg::OFF_STATUS) begin
        s_d.rData[4:0]                           = s_q.chanAct;
        s_d.rData[adc_seq_pkg::STAT_REF_LO +: 2] = s_q.refAct;
        s_d.rData[adc_seq_pkg::STAT_BUSY]        = s_q.st != adc_seq_pkg::ST_IDLE;
      end else begin
        s_d.rResp = adc_seq_pkg::RESP_SLVERR;
      end
    end

    // ----------------------------------------------------------------------
    // Conversion sequence
    // ----------------------------------------------------------------------
    done    = 1'b0;
    lastCyc = (s_q.st == adc_seq_pkg::ST_CONV) && (s_q.cyc == lastT);
    case (s_q.st)
      adc_seq_pkg::ST_IDLE: begin
        if (tick && s_q.startBit) begin
          s_d.cyc = 9'h000;
          if (s_q.firstConv && initTicks(s_q.initial_delay) != 9'h000) begin
            s_d.st = adc_seq_pkg::ST_INIT;
          end else begin
            s_d.st = adc_seq_pkg::ST_CONV;
          end
          s_d.firstConv = 1'b0;
        end
      end
      adc_seq_pkg::ST_INIT: begin
        if (tick) begin
          if (s_q.cyc == initTicks(s_q.initial_delay) - 9'h001) begin
            s_d.cyc = 9'h000;
            s_d.st  = adc_seq_pkg::ST_CONV;
          end else begin
            s_d.cyc = s_q.cyc + 9'h001;
          end
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (tick) begin
          if (s_q.cyc == sampT - 9'h001) begin
            s_d.ana.hold = 1'b1;
          end
          if (lastCyc) begin
            done = 1'b1;
            s_d.cyc = 9'h000;
            if (!(s_q.freeRun && s_q.startBit)) begin
              s_d.st       = adc_seq_pkg::ST_IDLE;
              s_d.startBit = evtEdge;
            end
          end else begin
            s_d.cyc = s_q.cyc + 9'h001;
          end
        end
      end
      default: begin
        s_d.st = adc_seq_pkg::ST_IDLE;
      end
    endcase

    if (done) begin
      s_d.result = anaOverRange ? adc_seq_pkg::FULL_SCALE : anaResult;
      s_d.resEvt = 1'b1;
      setFlag    = 1'b1;
    end
    // A completion in the same cycle as a clear keeps the flag set.
    s_d.flag = setFlag || (s_q.flag && !clrFlag);

    // Temporary selection copied while idle and in the final cycle only.
    if (s_q.enable && (s_q.st == adc_seq_pkg::ST_IDLE || lastCyc)) begin
      s_d.chanAct = s_q.chanTmp;
      s_d.refAct  = s_q.refTmp;
    end

    // Disabled converter holds the sequence in reset.
    if (!s_d.enable) begin
      s_d.st        = adc_seq_pkg::ST_IDLE;
      s_d.cyc       = 9'h000;
      s_d.startBit  = 1'b0;
      s_d.firstConv = 1'b1;
      s_d.ana.hold  = 1'b0;
    end

    s_d.ana.powerOn       = s_d.enable;
    s_d.ana.busy          = s_d.st == adc_seq_pkg::ST_CONV;
    s_d.ana.sampling      = (s_d.st == adc_seq_pkg::ST_CONV) && (s_d.cyc < sampT);
    s_d.ana.channel       = s_d.chanAct;
    s_d.ana.reference     = s_d.refAct;
    s_d.ana.internalRefOn = s_d.enable && s_d.refAct == adc_seq_pkg::REF_INTERNAL;
    s_d.ana.tempSensorOn  = s_d.enable && s_d.chanAct == TEMP_CHANNEL;
    s_d.ana.capSel        = s_d.capSel;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q           <= '0;
      s_q.firstConv <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = !s_q.awHave;
  assign s_axi_wready  = !s_q.wHave;
  assign s_axi_bvalid  = s_q.bValid;
  assign s_axi_bresp   = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid  = s_q.rValid;
  assign s_axi_rdata   = s_q.rData;
  assign s_axi_rresp   = s_q.rResp;
  assign anaCtl        = s_q.ana;
  assign resultReady   = s_q.flag;
  assign resultEvent   = s_q.resEvt;

endmodule : adc_conversion_sequencer

`default_nettype wire

// File: adc_seq_pkg.sv
// Constants, register map and carrier types of the converter sequencer.
// Assumes a single 25 MHz peripheral clock and an analog core that accepts the control bundle.

package adc_seq_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          IDX_W        = 5;
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_CONF     = 5'h04;
  localparam logic [4:0]  OFF_SAMPCTRL = 5'h08;
  localparam logic [4:0]  OFF_CHANNEL  = 5'h0c;
  localparam logic [4:0]  OFF_COMMAND  = 5'h10;
  localparam logic [4:0]  OFF_FLAGS    = 5'h14;
  localparam logic [4:0]  OFF_RESULT   = 5'h18;
  localparam logic [4:0]  OFF_STATUS   = 5'h1c;

  // Field positions.
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_FREERUN = 1;
  localparam int CTRL_EVTEN   = 2;
  localparam int CONF_DIV_LO  = 0;
  localparam int CONF_REF_LO  = 4;
  localparam int CONF_CAP     = 6;
  localparam int CONF_DLY_LO  = 8;
  localparam int CONF_INIT_LO = 12;
  localparam int STAT_REF_LO  = 8;
  localparam int STAT_BUSY    = 16;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Conversion timing in conversion clock cycles, full-scale code, reference code and clock rates
  // ----------------------------------------------------------------------
  localparam logic [8:0]  HOLD_CYCLES     = 9'h002;
  localparam logic [8:0]  CONV_CYCLES     = 9'h00d;
  localparam logic [8:0]  INIT_UNIT       = 9'h008;
  localparam logic [2:0]  INIT_SEL_MAX    = 3'h5;
  localparam logic [9:0]  FULL_SCALE      = 10'h3ff;
  localparam logic [1:0]  REF_INTERNAL    = 2'h0;
  localparam int          PERIPH_MIN_KHZ  = 100;
  localparam int          CLK_KHZ         = 25000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INIT = 2'b01,
    ST_CONV = 2'b11
  } seq_state_t;

  // Control bundle towards the analog core.
  typedef struct packed {
    logic       powerOn;
    logic       busy;
    logic       sampling;
    logic       hold;
    logic [4:0] channel;
    logic [1:0] reference;
    logic       internalRefOn;
    logic       tempSensorOn;
    logic       capSel;
  } ana_ctl_t;

  // Prescaler state.
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } clock_divider_select_state_t;

  // Whole sequencer state.
  typedef struct packed {
    logic [IDX_W-1:0] awIdx;
    logic             awHave;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             wHave;
    logic             bValid;
    logic [1:0]       bResp;
    logic             rValid;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic             enable;
    logic             freeRun;
    logic             evtEn;
    logic [2:0]       divSel;
    logic [1:0]       refTmp;
    logic             capSel;
    logic [3:0]       sample_delay;
    logic [2:0]       initial_delay;
    logic [4:0]       sample_length;
    logic [4:0]       chanTmp;
    logic             startBit;
    logic             flag;
    logic [9:0]       result;
    logic             resEvt;
    logic [4:0]       chanAct;
    logic [1:0]       refAct;
    seq_state_t       st;
    logic [8:0]       cyc;
    logic             firstConv;
    logic             evtPrev;
    ana_ctl_t         ana;
  } seq_t;

endpackage : adc_seq_pkg

// File: adc_prescaler.sv
// Conversion clock prescaler: one tick per rising edge of the divided clock.
// Assumes run is a registered level from the sequencer.

`timescale 1ns/1ns
`default_nettype none

module adc_prescaler (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       run,
  input  wire logic [2:0] divSel,
  output logic            tick
);

  adc_seq_pkg::clock_divider_select_state_t s_q;
  adc_seq_pkg::clock_divider_select_state_t s_d;

  // Half of the division factor 2 << divSel.
  function automatic logic [7:0] halfFactor(input logic [2:0] sel);
    halfFactor = 8'h01 << sel;
  endfunction : halfFactor

  always_comb begin
    s_d = s_q;
    if (!run) begin
      s_d.cnt  = 8'h00;
      s_d.tick = 1'b0;
    end else begin
      s_d.tick = (s_q.cnt == halfFactor(divSel));
      if (s_q.cnt == ((halfFactor(divSel) << 1) - 8'h01)) begin
        s_d.cnt = 8'h00;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : adc_prescaler

`default_nettype wire

// File: adc_seq_properties.sv
// Concurrent checks of the converter sequencer, watching its top-level ports only.
// Assumes a single clock domain and the asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module adc_seq_properties (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire adc_seq_pkg::ana_ctl_t anaCtl,
  input wire logic                  resultReady,
  input wire logic                  resultEvent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_off_idle: assert property (!anaCtl.powerOn |-> !anaCtl.busy && !anaCtl.sampling)
    else $error("converter active while disabled");
  a_sample_at_start: assert property ($rose(anaCtl.busy) |-> anaCtl.sampling)
    else $error("sampling not open at conversion start");
  a_sampling_busy: assert property (anaCtl.sampling |-> anaCtl.busy)
    else $error("sampling outside a conversion");
  a_hold_busy: assert property (anaCtl.hold |-> anaCtl.busy)
    else $error("hold outside a conversion");
  a_hold_once: assert property (anaCtl.hold |=> !anaCtl.hold)
    else $error("hold pulse longer than one cycle");
  a_conv_min_len: assert property ($rose(anaCtl.busy) |-> anaCtl.busy [*8])
    else $error("conversion ended too early");
  a_sel_frozen: assert property ($rose(anaCtl.busy) |=>
    ($stable(anaCtl.channel) && $stable(anaCtl.reference)) [*8])
    else $error("selection changed during conversion");
  a_ready_with_event: assert property (resultEvent |-> resultReady)
    else $error("completion without result-ready flag");
  a_event_single: assert property (resultEvent |=> !resultEvent)
    else $error("completion pulse longer than one cycle");
endmodule : adc_seq_properties

bind adc_conversion_sequencer adc_seq_properties adc_seq_properties_i (
  .clk(clk), .arst_n(arst_n), .anaCtl(anaCtl),
  .resultReady(resultReady), .resultEvent(resultEvent)
);

`default_nettype wire

// File: adc_core_model.sv
// Behavioural analog core: captures a code at the hold pulse, made from channel and reference.
// Assumes the sequencer samples the result only at the end of a conversion.
`timescale 1ns/1ns
`default_nettype none

module adc_core_model #(
  parameter logic [4:0] OVER_CHANNEL = 5'h07
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire adc_seq_pkg::ana_ctl_t anaCtl,
  output logic [9:0]                 anaResult,
  output logic                       anaOverRange
);
  // Outside a conversion the outputs keep changing, so a stale sample never looks valid.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      anaResult    <= 10'h000;
      anaOverRange <= 1'b0;
    end else if (anaCtl.hold) begin
      anaResult    <= {anaCtl.channel, 3'h0, anaCtl.reference};
      anaOverRange <= (anaCtl.channel == OVER_CHANNEL);
    end else if (!anaCtl.busy) begin
      anaResult    <= ~anaResult;
      anaOverRange <= ~anaOverRange;
    end
  end
endmodule : adc_core_model

`default_nettype wire

// File: adc_conversion_sequencer_tb.sv
// Self-checking bench of the converter sequencer over its AXI4-Lite register port.
// Assumes the core model and the bound property checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin numChecks++; if ((a) !== (e)) begin failCount++; \
  $display("BAD %s exp %h got %h", n, e, a); end end

module adc_conversion_sequencer_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, eventIn = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [9:0] anaResult;
  logic anaOverRange, resultReady, resultEvent;
  adc_seq_pkg::ana_ctl_t anaCtl;
  logic bvP = 1'b0, busyP = 1'b0, rdyP = 1'b0, smpP = 1'b0;
  int cyc = 0, tBv, tBusy, tRdy, tEvt, tSmp, smpW, evtCnt = 0, evtGap, failCount = 0, numChecks = 0;
  int t0, n0;

  adc_conversion_sequencer adc_conversion_sequencer_i (.clk, .arst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eventIn, .anaResult,
    .anaOverRange, .anaCtl, .resultReady, .resultEvent);
  adc_core_model adc_core_model_i (.clk, .arst_n, .anaCtl, .anaResult, .anaOverRange);

  always #20 clk = ~clk;

  // Edge stamps of the port activity, and the hang limit.
  always @(posedge clk) begin
    cyc++;
    if (s_axi_bvalid && !bvP) tBv = cyc;
    if (anaCtl.busy && !busyP) tBusy = cyc;
    if (resultReady && !rdyP) tRdy = cyc;
    if (anaCtl.sampling && !smpP) tSmp = cyc;
    if (!anaCtl.sampling && smpP) smpW = cyc - tSmp;
    if (resultEvent) begin
      evtGap = cyc - tEvt;
      tEvt = cyc;
      evtCnt++;
    end
    {bvP, busyP, rdyP, smpP} = {s_axi_bvalid, anaCtl.busy, resultReady, anaCtl.sampling};
    if (cyc == 20000) begin
      failCount++;
      finalReport();
    end
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= {3'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr

  task automatic chk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= {3'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask : chk

  task automatic waitEvt();
    int k;
    k = evtCnt;
    while (evtCnt == k) @(posedge clk);
  endtask : waitEvt

  // Lets the edge stamps of the completion settle before they are read.
  task automatic waitRdy();
    wait (resultReady);
    repeat (2) @(posedge clk);
  endtask : waitRdy

  task automatic finalReport();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finalReport

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(adc_seq_pkg::OFF_CTRL, 32'h0, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_FLAGS, 32'h0, adc_seq_pkg::RESP_OKAY);
    chk(5'h02, 32'h0, adc_seq_pkg::RESP_SLVERR);
    wr(5'h02, 32'h1, adc_seq_pkg::RESP_SLVERR);
    wr(adc_seq_pkg::OFF_CHANNEL, 32'h3, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_COMMAND, 32'h1, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_STATUS, 32'h0, adc_seq_pkg::RESP_OKAY);
    `CHK("powerOn", 1'b0, anaCtl.powerOn)
    $display("test registers done");
    // Divider select 0 gives a factor of 2, so half of it plus two is 3 cycles.
    wr(adc_seq_pkg::OFF_CONF, 32'h0, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_CTRL, 32'h1, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_COMMAND, 32'h1, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_COMMAND, 32'h1, adc_seq_pkg::RESP_OKAY);
    t0 = tBv;
    wr(adc_seq_pkg::OFF_CHANNEL, 32'h5, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_STATUS, 32'h10003, adc_seq_pkg::RESP_OKAY);
    waitRdy();
    `CHK("startDelay", 3, tBusy - t0)
    `CHK("convLen", 26, tRdy - tBusy)
    chk(adc_seq_pkg::OFF_COMMAND, 32'h0, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_RESULT, 32'h060, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_FLAGS, 32'h0, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_STATUS, 32'h5, adc_seq_pkg::RESP_OKAY);
    $display("test single done");
    wr(adc_seq_pkg::OFF_SAMPCTRL, 32'h3, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_CONF, 32'h200, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_COMMAND, 32'h1, adc_seq_pkg::RESP_OKAY);
    waitRdy();
    `CHK("sampWin", 14, smpW)
    `CHK("convLenExt", 36, tRdy - tBusy)
    wr(adc_seq_pkg::OFF_FLAGS, 32'h1, adc_seq_pkg::RESP_OKAY);
    `CHK("flagPort", 1'b0, resultReady)
    wr(adc_seq_pkg::OFF_CHANNEL, 32'h7, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_COMMAND, 32'h1, adc_seq_pkg::RESP_OKAY);
    waitRdy();
    chk(adc_seq_pkg::OFF_RESULT, 32'h3ff, adc_seq_pkg::RESP_OKAY);
    $display("test window done");
    wr(adc_seq_pkg::OFF_CHANNEL, 32'h2, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_CTRL, 32'h5, adc_seq_pkg::RESP_OKAY);
    n0 = evtCnt;
    eventIn <= 1'b1;
    waitRdy();
    chk(adc_seq_pkg::OFF_RESULT, 32'h040, adc_seq_pkg::RESP_OKAY);
    repeat (100) @(posedge clk);
    `CHK("evtOnce", n0 + 1, evtCnt)
    eventIn <= 1'b0;
    $display("test event done");
    wr(adc_seq_pkg::OFF_CTRL, 32'h3, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_CHANNEL, 32'h4, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_COMMAND, 32'h1, adc_seq_pkg::RESP_OKAY);
    waitEvt();
    wr(adc_seq_pkg::OFF_CHANNEL, 32'h6, adc_seq_pkg::RESP_OKAY);
    waitEvt();
    chk(adc_seq_pkg::OFF_RESULT, 32'h080, adc_seq_pkg::RESP_OKAY);
    waitEvt();
    `CHK("freeGap", 36, evtGap)
    chk(adc_seq_pkg::OFF_RESULT, 32'h0c0, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_COMMAND, 32'h0, adc_seq_pkg::RESP_OKAY);
    repeat (100) @(posedge clk);
    $display("test freerun done");
    wr(adc_seq_pkg::OFF_CTRL, 32'h1, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_CONF, 32'h10, adc_seq_pkg::RESP_OKAY);
    chk(adc_seq_pkg::OFF_STATUS, 32'h106, adc_seq_pkg::RESP_OKAY);
    `CHK("extRef", 1'b0, anaCtl.internalRefOn)
    wr(adc_seq_pkg::OFF_CONF, 32'h40, adc_seq_pkg::RESP_OKAY);
    wr(adc_seq_pkg::OFF_CHANNEL, 32'h1e, adc_seq_pkg::RESP_OKAY);
    repeat (4) @(posedge clk);
    `CHK("tempOn", 1'b1, anaCtl.tempSensorOn)
    `CHK("intRef", 1'b1, anaCtl.internalRefOn)
    `CHK("capSel", 1'b1, anaCtl.capSel)
    wr(adc_seq_pkg::OFF_CTRL, 32'h0, adc_seq_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("powerOff", 1'b0, anaCtl.powerOn)
    $display("test temp done");
    finalReport();
  end
endmodule : adc_conversion_sequencer_tb

`default_nettype wire
